/* serial_flow_control_port.sv */
// serial port with software and hardware flow control, APB register access
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "sfcp_defs.svh"

// Function
// - stored receive, software flow: one DC1 sent on start command
// - stored receive, software flow: no further flow characters after that DC1
// - software flow: DTR high in any mode, RTS high from start, both held
// - streaming mode selection drives DTR high at once
// - streaming software start: RTS high, DC1 every 100 ms until first character
// - streaming: execution starts after 20 events buffered, reception continues
// - streaming software flow: send DC3 when free space falls to 50
// - streaming software flow: send DC1 once free space exceeds 200
// - end character E: stop receiving, discard later input, transmit nothing
// - drained buffer stalls execution until look-ahead events are buffered
// - software transmit starts sending only while CTS is high
// - far end pauses transmit with DC3 and restarts with DC1, repeatedly
// - transmit mode inserts no flow characters into the output
// - hardware stored receive: DTR on mode entry, RTS on start, held
// - hardware streaming start drives RTS high before sender begins
// - hardware streaming: RTS low when free space falls to 50
// - hardware streaming: RTS high again once free space exceeds 200
// - hardware transmit sends while CTS high, pauses while low
// - seven data bits plus eighth bit of even parity or zero
// - carriage return is 0D, line feed is 0A
// - parity off: send zero parity bit, ignore received parity bit
// - DC3 is 13 hex, DC1 is 11 hex
module serial_flow_control_port #(
	parameter int unsigned CLKS_PER_BIT   = 2170,
	parameter int unsigned RXBUF_DEPTH    = 256,
	parameter int unsigned LOOK_EVENTS    = 2,
	parameter int unsigned XON_REPEAT_CYC = 32'(`XON_REPEAT_CYC)
) (
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        RXD_I,
	input  wire logic        CTS_I,
	output logic             TXD_O,
	output logic             RTS_O,
	output logic             DTR_O
);
	import sfcp_pkg::*;

	localparam int AW = $clog2(RXBUF_DEPTH);
	localparam logic [AW:0] DEPTH_L  = (AW+1)'(RXBUF_DEPTH);
	localparam logic [AW:0] STOP_L   = (AW+1)'(`STOP_FREE);
	localparam logic [AW:0] RESUME_L = (AW+1)'(`RESUME_FREE);
	localparam logic [AW:0] START_L  = (AW+1)'(`START_EVENTS);
	localparam logic [AW:0] LOOK_L   = (AW+1)'(LOOK_EVENTS);
	localparam logic [15:0] BIT_L    = 16'(CLKS_PER_BIT - 1);
	localparam logic [15:0] HALF_L   = 16'(CLKS_PER_BIT / 2);
	localparam logic [31:0] XON_L    = 32'(XON_REPEAT_CYC - 1);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] in_s1_r, in_s2_r, in_s3_r, in_f_r;
	logic       rxd_f, cts_f;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			in_s1_r <= 2'h3;
			in_s2_r <= 2'h3;
			in_s3_r <= 2'h3;
			in_f_r  <= 2'h3;
		end else begin
			in_s1_r <= {CTS_I, RXD_I};
			in_s2_r <= in_s1_r;
			in_s3_r <= in_s2_r;
			for (int i = 0; i < 2; i++) begin
				if (in_s2_r[i] == in_s3_r[i])
					in_f_r[i] <= in_s3_r[i];
			end
		end
	end
	assign rxd_f = in_f_r[0];
	assign cts_f = in_f_r[1];

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	mode_e       mode_r;
	logic        sw_r, par_r, start_p_r, started_r;
	logic        pready_r, pslverr_r, perr_r;
	logic [31:0] prdata_r;
	logic        hold_vld_r, rts_r, dtr_r, exec_run_r, done_r, rx_started_r;
	logic        paused_r, tx_go_r;
	logic [6:0]  hold_ch_r;
	logic [AW:0] count_r, free_w;
	logic [6:0]  head_w;
	logic        access, done_xfer, stall, ctrl_wr, pop;
	tx_state_e   tx_state_r;

	assign access    = PSEL_I & PENABLE_I;
	assign stall     = PWRITE_I & (PADDR_I == `OFS_TXD) & hold_vld_r;
	assign done_xfer = access & pready_r;
	assign ctrl_wr   = done_xfer & PWRITE_I & (PADDR_I == `OFS_CTRL);
	assign pop       = done_xfer & ~PWRITE_I & (PADDR_I == `OFS_RXD) & prdata_r[`RXD_VALID_BIT];
	assign free_w    = DEPTH_L - count_r;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= access & ~pready_r & ~stall;
			pslverr_r <= 1'b0;
			if (access & ~pready_r & ~stall) begin
				prdata_r <= 32'h0;
				case (PADDR_I)
					`OFS_CTRL: prdata_r[3:0] <= {par_r, sw_r, mode_r};
					`OFS_STAT: prdata_r <= {(16-AW-1)'(0), free_w, 8'h0,
						tx_state_r == TX_SHIFT, rx_started_r, paused_r, perr_r,
						done_r, exec_run_r, dtr_r, rts_r};
					`OFS_TXD:  prdata_r[7:0] <= {hold_vld_r, hold_ch_r};
					`OFS_RXD:  prdata_r[8:0] <= {count_r != '0, 1'b0, head_w};
					default:   pslverr_r <= 1'b1;
				endcase
			end
		end
	end

	// control register and start pulse
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			{par_r, sw_r} <= 2'b00;
			mode_r        <= MODE_IDLE;
			start_p_r     <= 1'b0;
			started_r     <= 1'b0;
		end else begin
			start_p_r <= ctrl_wr & PWDATA_I[`CTRL_START_BIT] & (PWDATA_I[1:0] != 2'b00);
			if (ctrl_wr) begin
				mode_r    <= mode_e'(PWDATA_I[`CTRL_MODE_LSB +: 2]);
				sw_r      <= PWDATA_I[`CTRL_SW_BIT];
				par_r     <= PWDATA_I[`CTRL_PAR_BIT];
				started_r <= 1'b0;
			end else if (start_p_r)
				started_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	rx_state_e   rx_state_r;
	logic [15:0] rx_cnt_r;
	logic [2:0]  rx_bit_r;
	logic [7:0]  rx_sh_r;
	logic        rx_vld_r;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rx_state_r <= RX_IDLE;
			rx_cnt_r   <= 16'h0;
			rx_bit_r   <= 3'h0;
			rx_sh_r    <= 8'h0;
			rx_vld_r   <= 1'b0;
		end else begin
			rx_vld_r <= 1'b0;
			if (rx_cnt_r != 16'h0)
				rx_cnt_r <= rx_cnt_r - 16'h1;
			case (rx_state_r)
				RX_IDLE: if (!rxd_f) begin
					rx_state_r <= RX_START;
					rx_cnt_r   <= HALF_L;
				end
				RX_START: if (rx_cnt_r == 16'h0) begin
					rx_state_r <= rxd_f ? RX_IDLE : RX_DATA;
					rx_cnt_r   <= BIT_L;
					rx_bit_r   <= 3'h0;
				end
				RX_DATA: if (rx_cnt_r == 16'h0) begin
					rx_sh_r  <= {rxd_f, rx_sh_r[7:1]};
					rx_cnt_r <= BIT_L;
					rx_bit_r <= rx_bit_r + 3'h1;
					if (rx_bit_r == 3'h7)
						rx_state_r <= RX_STOP;
				end
				RX_STOP: if (rx_cnt_r == 16'h0) begin
					// one stop bit is enough for one- or two-stop senders
					rx_state_r <= RX_IDLE;
					rx_vld_r   <= rxd_f;
				end
				default: rx_state_r <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receive buffer and session flags
	// ----------------------------------------------------------------
	logic [6:0]    mem [RXBUF_DEPTH];
	logic [AW-1:0] wr_ptr_r, rd_ptr_r;
	logic [AW:0]   evt_r;
	logic          accept, is_end, push, exec_once_r;

	assign accept = started_r & (mode_r == MODE_RECV | mode_r == MODE_STREAM) & ~done_r;
	assign is_end = (mode_r == MODE_STREAM) & (rx_sh_r[6:0] == `CH_END);
	assign push   = rx_vld_r & accept & ~is_end & (count_r != DEPTH_L);
	assign head_w = mem[rd_ptr_r];

	always_ff @(posedge CLK_I) begin
		if (push)
			mem[wr_ptr_r] <= rx_sh_r[6:0]; // parity bit dropped
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			evt_r    <= '0;
		end else if (ctrl_wr) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			evt_r    <= '0;
		end else begin
			if (push)
				wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
			if (pop)
				rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
			// an event ends at line feed
			evt_r <= evt_r + (AW+1)'(push & rx_sh_r[6:0] == `CH_LF)
				- (AW+1)'(pop & head_w == `CH_LF);
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			done_r       <= 1'b0;
			rx_started_r <= 1'b0;
			perr_r       <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				done_r       <= 1'b0;
				rx_started_r <= 1'b0;
			end else if (rx_vld_r & accept) begin
				rx_started_r <= 1'b1;
				if (is_end)
					done_r <= 1'b1;
			end
			// set wins over write-one clear; ignored with parity off
			if (rx_vld_r & par_r & ^rx_sh_r)
				perr_r <= 1'b1;
			else if (done_xfer & PWRITE_I & PADDR_I == `OFS_STAT & PWDATA_I[`STAT_PERR_BIT])
				perr_r <= 1'b0;
		end
	end

	// execution gate for streaming
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			exec_run_r  <= 1'b0;
			exec_once_r <= 1'b0;
		end else if (ctrl_wr | mode_r != MODE_STREAM) begin
			exec_run_r  <= 1'b0;
			exec_once_r <= 1'b0;
		end else if (!exec_run_r) begin
			if ((!exec_once_r & evt_r >= START_L)
				| (exec_once_r & (evt_r >= LOOK_L | done_r))) begin
				exec_run_r  <= 1'b1;
				exec_once_r <= 1'b1;
			end
		end else if (count_r == '0 & ~done_r)
			exec_run_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// flow control lines and characters
	// ----------------------------------------------------------------
	logic        pend_r, xoff_r, tx_start;
	logic [6:0]  pend_ch_r;
	logic [31:0] xon_tmr_r;
	logic        sw_stream;

	assign sw_stream = sw_r & mode_r == MODE_STREAM & started_r;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dtr_r <= 1'b0;
			rts_r <= 1'b0;
		end else begin
			dtr_r <= mode_r != MODE_IDLE;
			if (ctrl_wr)
				rts_r <= 1'b0;
			else if (start_p_r)
				rts_r <= 1'b1;
			else if (~sw_r & mode_r == MODE_STREAM & started_r) begin
				// 50-slot margin absorbs sender overrun
				if (free_w <= STOP_L)
					rts_r <= 1'b0;
				else if (free_w > RESUME_L)
					rts_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pend_r    <= 1'b0;
			pend_ch_r <= `CH_DC1;
			xoff_r    <= 1'b0;
			xon_tmr_r <= 32'h0;
		end else if (ctrl_wr | done_r) begin
			pend_r    <= 1'b0;
			xoff_r    <= 1'b0;
		end else if (start_p_r & sw_r & (mode_r == MODE_RECV | mode_r == MODE_STREAM)) begin
			pend_r    <= 1'b1;
			pend_ch_r <= `CH_DC1;
			xon_tmr_r <= XON_L;
		end else if (tx_start & pend_r)
			pend_r <= 1'b0; // stored receive sends nothing more
		else if (sw_stream & ~rx_started_r) begin
			xon_tmr_r <= xon_tmr_r - 32'h1;
			if (xon_tmr_r == 32'h0) begin
				pend_r    <= 1'b1;
				pend_ch_r <= `CH_DC1;
				xon_tmr_r <= XON_L;
			end
		end else if (sw_stream & free_w <= STOP_L & ~xoff_r) begin
			pend_r    <= 1'b1;
			pend_ch_r <= `CH_DC3;
			xoff_r    <= 1'b1;
		end else if (sw_stream & free_w > RESUME_L & xoff_r) begin
			pend_r    <= 1'b1;
			pend_ch_r <= `CH_DC1;
			xoff_r    <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// transmit gating and holding register
	// ----------------------------------------------------------------
	logic tx_allow;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			paused_r   <= 1'b0;
			tx_go_r    <= 1'b0;
			hold_vld_r <= 1'b0;
			hold_ch_r  <= 7'h0;
		end else begin
			if (ctrl_wr) begin
				paused_r <= 1'b0;
				tx_go_r  <= 1'b0;
			end else begin
				if (started_r & cts_f & mode_r == MODE_XMIT)
					tx_go_r <= 1'b1;
				if (rx_vld_r & sw_r & mode_r == MODE_XMIT) begin
					if (rx_sh_r[6:0] == `CH_DC3)
						paused_r <= 1'b1;
					else if (rx_sh_r[6:0] == `CH_DC1)
						paused_r <= 1'b0;
				end
			end
			if (done_xfer & PWRITE_I & PADDR_I == `OFS_TXD) begin
				hold_vld_r <= 1'b1;
				hold_ch_r  <= PWDATA_I[6:0];
			end else if (ctrl_wr | (tx_start & ~pend_r))
				hold_vld_r <= 1'b0;
		end
	end

	assign tx_allow = sw_r ? (tx_go_r & ~paused_r) : cts_f;
	// flow characters are never queued in transmit mode
	// nothing leaves once the end character is seen
	assign tx_start = tx_state_r == TX_IDLE & ~done_r & (pend_r | (mode_r == MODE_XMIT
		& started_r & hold_vld_r & tx_allow));

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	logic [9:0]  tx_sh_r;
	logic [15:0] tx_cnt_r;
	logic [3:0]  tx_bit_r;
	logic [6:0]  tx_ch;
	logic        txd_r;

	assign tx_ch = pend_r ? pend_ch_r : hold_ch_r;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			tx_state_r <= TX_IDLE;
			tx_sh_r    <= 10'h3FF;
			tx_cnt_r   <= 16'h0;
			tx_bit_r   <= 4'h0;
			txd_r      <= 1'b1;
		end else begin
			case (tx_state_r)
				TX_IDLE: if (tx_start) begin
					// even parity or zero
					tx_sh_r    <= {1'b1, par_r & ^tx_ch, tx_ch, 1'b0};
					tx_state_r <= TX_SHIFT;
					tx_cnt_r   <= BIT_L;
					tx_bit_r   <= 4'h0;
					txd_r      <= 1'b0;
				end
				TX_SHIFT: if (tx_cnt_r != 16'h0)
					tx_cnt_r <= tx_cnt_r - 16'h1;
				else if (tx_bit_r == 4'h9) begin
					tx_state_r <= TX_IDLE;
					txd_r      <= 1'b1;
				end else begin
					tx_bit_r <= tx_bit_r + 4'h1;
					tx_cnt_r <= BIT_L;
					txd_r    <= tx_sh_r[tx_bit_r + 4'h1];
				end
				default: tx_state_r <= TX_IDLE;
			endcase
		end
	end

	assign PRDATA_O  = prdata_r;
	assign PREADY_O  = pready_r;
	assign PSLVERR_O = pslverr_r;
	assign TXD_O     = txd_r;
	assign RTS_O     = rts_r;
	assign DTR_O     = dtr_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic [1:0] recv_flow_cnt_r;
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			recv_flow_cnt_r <= 2'h0;
		else if (ctrl_wr)
			recv_flow_cnt_r <= 2'h0;
		else if (tx_start & pend_r & mode_r == MODE_RECV & recv_flow_cnt_r != 2'h3)
			recv_flow_cnt_r <= recv_flow_cnt_r + 2'h1;
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);

	a_dtr_follows: assert property (mode_r != MODE_IDLE && !ctrl_wr |=> DTR_O)
		else $error("dtr not high with mode selected");
	a_recv_one_dc1: assert property (recv_flow_cnt_r <= 2'h1)
		else $error("more than one flow character in stored receive");
	a_xmit_no_flow: assert property (mode_r == MODE_XMIT |-> !pend_r)
		else $error("flow character queued in transmit mode");
	a_rts_stop: assert property (~sw_r && mode_r == MODE_STREAM && started_r && !start_p_r
		&& !ctrl_wr && free_w <= STOP_L |=> !RTS_O)
		else $error("rts not dropped at stop level");
	a_rts_resume: assert property (~sw_r && mode_r == MODE_STREAM && started_r
		&& !ctrl_wr && free_w > RESUME_L |=> RTS_O)
		else $error("rts not raised above resume level");
	a_end_discard: assert property (done_r |-> !push && !tx_start)
		else $error("activity after end of load");
	a_exec_start: assert property ($rose(exec_run_r) && !$past(exec_once_r)
		|-> $past(evt_r) >= START_L)
		else $error("execution started early");
	a_pause_hold: assert property (mode_r == MODE_XMIT && sw_r && paused_r
		|-> !tx_start)
		else $error("transmit while paused");
	a_cts_gate: assert property (mode_r == MODE_XMIT && !sw_r && !cts_f
		|-> !tx_start)
		else $error("transmit with cts low");
	a_parity_bit: assert property (tx_start |=> tx_sh_r[8] == (par_r & ^tx_sh_r[7:1])
		&& txd_r == 1'b0)
		else $error("wrong parity or start bit");

	c_dc3_sent: cover property (tx_start && pend_r && pend_ch_r == `CH_DC3);
	c_end_seen: cover property ($rose(done_r));
	c_exec_stall: cover property ($fell(exec_run_r));
	c_tx_pause: cover property ($rose(paused_r) ##[1:1000] $fell(paused_r));

endmodule : serial_flow_control_port

/* sfcp_defs.svh */
// register offsets, field positions, character codes and timing counts
`ifndef SFCP_DEFS_SVH
`define SFCP_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STAT        8'h04
`define OFS_TXD         8'h08
`define OFS_RXD         8'h0C
`define CTRL_MODE_LSB   0
`define CTRL_SW_BIT     2
`define CTRL_PAR_BIT    3
`define CTRL_START_BIT  4
`define STAT_PERR_BIT   4
`define RXD_VALID_BIT   8
`define CTRL_RESET      5'h00

// ----------------------------------------------------------------
// character codes
// ----------------------------------------------------------------
`define CH_DC1          7'h11
`define CH_DC3          7'h13
`define CH_CR           7'h0D
`define CH_LF           7'h0A
`define CH_END          7'h45

// ----------------------------------------------------------------
// fill levels and timing
// ----------------------------------------------------------------
`define START_EVENTS    20
`define STOP_FREE       50
`define RESUME_FREE     200
`define XON_REPEAT_MS   100
`define CLK_PERIOD_PS   4000
`define XON_REPEAT_CYC  (64'd`XON_REPEAT_MS * 64'd1000000000 / 64'd`CLK_PERIOD_PS)

`endif

/* sfcp_pkg.sv */
// types shared by the serial flow control port
package sfcp_pkg;
	typedef enum logic [1:0] {
		MODE_IDLE   = 2'b00,
		MODE_RECV   = 2'b01,
		MODE_XMIT   = 2'b10,
		MODE_STREAM = 2'b11
	} mode_e;
	typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_e;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_e;
endpackage : sfcp_pkg

/* sfcp_far_end.sv */
// far-end serial device model: sender, receiver and clear-to-send line
`timescale 1ns/1ps
module sfcp_far_end #(
	parameter int B = 8
) (
	input  wire logic clk_i,
	input  wire logic txd_i,
	input  wire logic rts_i,
	input  wire logic sw_i,
	input  wire logic par_i,
	output logic      rxd_o,
	output logic      cts_o
);
	logic [7:0] got[$];
	logic       xoff = 1'b0;
	logic [9:0] f;
	logic [7:0] b;

	initial begin
		rxd_o = 1'b1;
		cts_o = 1'b1;
	end

	// ----------------------------------------------------------------
	// sender: waits before each character while paused by the device
	// ----------------------------------------------------------------
	task automatic send(input logic [6:0] c);
		while (sw_i ? xoff : !rts_i) @(posedge clk_i);
		f = {1'b1, par_i & ^c, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rxd_o <= f[i];
			repeat (B - 1) @(posedge clk_i);
		end
	endtask : send

	// ----------------------------------------------------------------
	// receiver: mid-bit sampling, framed characters only
	// ----------------------------------------------------------------
	initial forever begin
		@(negedge txd_i);
		repeat (B / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (B) @(posedge clk_i);
			b[i] = txd_i;
		end
		repeat (B) @(posedge clk_i);
		if (txd_i)
			got.push_back(b);
		if (b[6:0] === 7'h13)
			xoff = 1'b1;
		else if (b[6:0] === 7'h11)
			xoff = 1'b0;
	end
endmodule : sfcp_far_end

/* serial_flow_control_port_tb.sv */
// self-checking bench for the serial flow control port
`timescale 1ns/1ps
`include "sfcp_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module serial_flow_control_port_tb;
	localparam int B = 8;
	typedef struct packed {logic [4:0] ctrl; logic [1:0] dr;} row_s;
	logic        CLK_I, RESETN_I, PSEL_I, PENABLE_I, PWRITE_I;
	logic [7:0]  PADDR_I;
	logic [31:0] PWDATA_I, PRDATA_O, rd;
	logic        PREADY_O, PSLVERR_O, TXD_O, RTS_O, DTR_O, RXD_I, CTS_I, serr;
	logic        sw = 1'b0;
	logic        par = 1'b0;
	int          err_count = 0;
	int          n_checks = 0;
	row_s        rows[7] = '{'{5'h10, 2'b00}, '{5'h15, 2'b11}, '{5'h01, 2'b10},
		'{5'h11, 2'b11}, '{5'h03, 2'b10}, '{5'h13, 2'b11}, '{5'h02, 2'b10}};

	serial_flow_control_port #(.CLKS_PER_BIT(B), .RXBUF_DEPTH(256), .LOOK_EVENTS(2),
		.XON_REPEAT_CYC(200)) u_serial_flow_control_port (.CLK_I(CLK_I),
		.RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
		.PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
		.PSLVERR_O(PSLVERR_O), .RXD_I(RXD_I), .CTS_I(CTS_I), .TXD_O(TXD_O),
		.RTS_O(RTS_O), .DTR_O(DTR_O));
	sfcp_far_end #(.B(B)) u_sfcp_far_end (.clk_i(CLK_I), .txd_i(TXD_O), .rts_i(RTS_O),
		.sw_i(sw), .par_i(par), .rxd_o(RXD_I), .cts_o(CTS_I));

	// ----------------------------------------------------------------
	// clock, watchdog, helpers
	// ----------------------------------------------------------------
	initial begin
		CLK_I = 1'b0;
		forever #2 CLK_I = ~CLK_I;
	end

	initial begin
		repeat (90000) @(posedge CLK_I);
		err_count++;
		end_of_test();
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	task automatic tick(input int n);
		repeat (n) @(posedge CLK_I);
	endtask : tick

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		PSEL_I    <= 1'b1;
		PWRITE_I  <= w;
		PADDR_I   <= a;
		PWDATA_I  <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		do @(posedge CLK_I); while (PREADY_O !== 1'b1);
		rd        = PRDATA_O;
		serr      = PSLVERR_O;
		PSEL_I    <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask : apb

	// ----------------------------------------------------------------
	// transmit: start gate, pause and resume
	// ----------------------------------------------------------------
	task automatic xmit(input logic s);
		sw = s;
		par = s;
		u_sfcp_far_end.cts_o <= 1'b0;
		u_sfcp_far_end.got.delete();
		apb(1, `OFS_CTRL, {27'h0, 1'b1, s, s, 2'b10});
		apb(1, `OFS_TXD, 32'h43);
		tick(300);
		`CHK(u_sfcp_far_end.got.size(), 0)
		u_sfcp_far_end.cts_o <= 1'b1;
		tick(300);
		`CHK(u_sfcp_far_end.got[0], {s, 7'h43})
		if (s)
			u_sfcp_far_end.send(`CH_DC3);
		else
			u_sfcp_far_end.cts_o <= 1'b0;
		tick(100);
		apb(1, `OFS_TXD, 32'h43);
		tick(300);
		`CHK(u_sfcp_far_end.got.size(), 1)
		if (s)
			u_sfcp_far_end.send(`CH_DC1);
		else
			u_sfcp_far_end.cts_o <= 1'b1;
		tick(300);
		`CHK(u_sfcp_far_end.got.size(), 2)
	endtask : xmit

	// ----------------------------------------------------------------
	// streaming: start, thresholds, drain stall, end of load
	// ----------------------------------------------------------------
	task automatic stream(input logic s);
		int n;
		sw = s;
		par = s;
		u_sfcp_far_end.got.delete();
		apb(1, `OFS_CTRL, {27'h0, 1'b1, 1'b0, s, 2'b11});
		tick(520);
		`CHK({RTS_O, DTR_O}, 2'b11)
		`CHK(u_sfcp_far_end.got.size() >= 2, s)
		u_sfcp_far_end.send(`CH_LF);
		tick(300);
		u_sfcp_far_end.got.delete();
		for (n = 1; n < 20; n++) begin
			apb(0, `OFS_STAT, 0);
			`CHK(rd[2], 1'b0)
			u_sfcp_far_end.send(`CH_LF);
		end
		tick(200);
		apb(0, `OFS_STAT, 0);
		`CHK({u_sfcp_far_end.got.size(), rd[2]}, {32'd0, 1'b1})
		for (n = 20; n < 206; n++) u_sfcp_far_end.send(7'h41);
		tick(200);
		apb(0, `OFS_STAT, 0);
		`CHK(rd[31:16], 16'd50)
		`CHK(s ? u_sfcp_far_end.got[$] : {7'h0, RTS_O}, s ? 8'h13 : 8'h0)
		apb(0, `OFS_RXD, 0);
		`CHK(rd, 32'h10A)
		for (n = 1; n < 150; n++) apb(0, `OFS_RXD, 0);
		tick(200);
		`CHK(s ? u_sfcp_far_end.got[$] : {7'h0, RTS_O}, s ? 8'h13 : 8'h0)
		apb(0, `OFS_RXD, 0);
		tick(200);
		`CHK(s ? u_sfcp_far_end.got[$] : {7'h0, RTS_O}, s ? 8'h11 : 8'h1)
		for (n = 0; n < 55; n++) apb(0, `OFS_RXD, 0);
		for (int k = 0; k < 3; k++) begin
			if (k > 0)
				u_sfcp_far_end.send(`CH_LF);
			tick(200);
			apb(0, `OFS_STAT, 0);
			`CHK(rd[2], k == 2)
		end
		n = u_sfcp_far_end.got.size();
		u_sfcp_far_end.send(`CH_END);
		u_sfcp_far_end.send(7'h42);
		tick(300);
		apb(0, `OFS_STAT, 0);
		`CHK({rd[31:16], rd[4], rd[3]}, {16'd254, 1'b0, 1'b1})
		`CHK(u_sfcp_far_end.got.size(), n)
	endtask : stream

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		RESETN_I  = 1'b0;
		PSEL_I    = 1'b0;
		PENABLE_I = 1'b0;
		PWRITE_I  = 1'b0;
		PADDR_I   = 8'h00;
		PWDATA_I  = 32'h0;
		repeat (6) @(posedge CLK_I);
		RESETN_I <= 1'b1;
		`CHK({TXD_O, RTS_O, DTR_O, PREADY_O}, 4'b1000)
		apb(0, `OFS_CTRL, 0);
		`CHK(rd, 32'h0)
		apb(0, 8'h10, 0);
		`CHK({serr, rd}, {1'b1, 32'h0})
		apb(1, `OFS_CTRL, 32'h1E);
		apb(0, `OFS_CTRL, 0);
		`CHK(rd, 32'h0E)
		foreach (rows[i]) begin
			apb(1, `OFS_CTRL, {27'h0, rows[i].ctrl});
			tick(100);
			apb(0, `OFS_STAT, 0);
			`CHK({DTR_O, RTS_O, rd[1:0]}, {2{rows[i].dr}})
		end
		sw = 1'b1;
		par = 1'b1;
		u_sfcp_far_end.got.delete();
		apb(1, `OFS_CTRL, 32'h1D);
		tick(300);
		`CHK({u_sfcp_far_end.got.size(), u_sfcp_far_end.got[0]}, {32'd1, 8'h11})
		u_sfcp_far_end.send(`CH_CR);
		u_sfcp_far_end.send(`CH_LF);
		tick(300);
		`CHK(u_sfcp_far_end.got.size(), 1)
		apb(0, `OFS_RXD, 0);
		`CHK(rd, 32'h10D)
		apb(0, `OFS_RXD, 0);
		`CHK(rd, 32'h10A)
		apb(0, `OFS_RXD, 0);
		`CHK(rd[8], 1'b0)
		xmit(1'b1);
		xmit(1'b0);
		stream(1'b1);
		stream(1'b0);
		end_of_test();
	end
endmodule : serial_flow_control_port_tb
